// file: inc/sadc_pkg.sv
`default_nettype none
package sadc_pkg;
	// Conversion timing
	localparam real QUANTIZE_TIME_NS  = 3200.0;
	localparam real CLOCK_PERIOD_NS   = 10.0;
	localparam int  QUANTIZE_CYCLES   = int'(QUANTIZE_TIME_NS / CLOCK_PERIOD_NS);
	localparam int  RESULT_BITS       = 16;
	localparam int  SAMPLE_CLOCKS_ONE = 16;
	localparam int  SAMPLE_CLOCKS_TWO = 14;
	localparam int  CONFIG_BITS       = 2;
	localparam logic [1:0] MUX_RESET  = 2'h2;

	typedef enum logic [1:0] {
		SADC_SAMPLE  = 2'b00,
		SADC_CONVERT = 2'b01,
		SADC_SLEEP   = 2'b10
	} sadc_state_e;

	// Analog front end selection driven to the converter core
	typedef struct packed {
		logic positiveIsB;
		logic negativeIsB;
		logic negativeIsGround;
	} sadc_mux_s;
endpackage
`default_nettype wire

// file: rtl/sadc_serial_interface.sv
// Behaviour
// - Trigger rising edge starts conversion; done after quantize time.
// - Trigger still high after conversion: enter sleep until trigger falls.
// - Trigger falling: sample mode, result output enabled; disabled while trigger high.
// - Each new result bit driven on shift clock falling edge.
// - After all result bits, zeros shifted while trigger stays low.
// - Result is unipolar straight binary, zero to full scale minus one LSB.
// - Two-channel variant takes 2 config bits on rising edges after trigger falls.
// - Further config bits ignored until next conversion cycle.
// - Both parties change on falling, sample on rising shift clock edges.
// - Config shifted in while result shifted out, full duplex.
// - Received config applies to next requested conversion, not current readout.
// - Pair/polarity decode: 10 A-gnd, 11 B-gnd, 00 A-B, 01 B-A.
// - Conversion completes within 3.2 us; host holds trigger high that long.
// - Sampling lasts 16 shift clocks (one-channel) or 14 (two-channel).
`timescale 1ns/1ps
`default_nettype none
module sadc_serial_interface #(
	parameter bit TWO_CHANNEL = 1'b1
) (
	input  wire logic                    clock,
	input  wire logic                    reset_n,
	input  wire logic                    sampleTrigger,
	input  wire logic                    shiftClock,
	input  wire logic                    serialConfigIn,
	input  wire logic [15:0]             convertedCode,
	output logic                         serialResultOut,
	output logic                         serialResultOe,
	output logic                         sampleMode,
	output logic                         sleepMode,
	output logic                         conversionDone,
	output sadc_pkg::sadc_mux_s          muxSelect
);

	// Two-flop synchronisers for pins; stage one read only by stage two
	logic [1:0] trigSync;
	logic [1:0] sckSync;
	logic [1:0] sdiSync;
	logic       trigLast;
	logic       sckLast;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			trigSync <= 2'h3;
			sckSync  <= 2'h0;
			sdiSync  <= 2'h0;
			trigLast <= 1'b1;
			sckLast  <= 1'b0;
		end
		else
		begin
			trigSync <= {trigSync[0], sampleTrigger};
			sckSync  <= {sckSync[0], shiftClock};
			sdiSync  <= {sdiSync[0], serialConfigIn};
			trigLast <= trigSync[1];
			sckLast  <= sckSync[1];
		end
	end

	wire trigHigh = trigSync[1];
	wire trigRise = trigSync[1] && !trigLast;
	wire trigFall = !trigSync[1] && trigLast;
	wire sckRise  = sckSync[1] && !sckLast;
	wire sckFall  = !sckSync[1] && sckLast;

	function automatic sadc_pkg::sadc_mux_s decodeMux(input logic [1:0] word);
		sadc_pkg::sadc_mux_s m;
		m = '0;
		case (word)
			2'b10:   m = '{positiveIsB: 1'b0, negativeIsB: 1'b0, negativeIsGround: 1'b1};
			2'b11:   m = '{positiveIsB: 1'b1, negativeIsB: 1'b0, negativeIsGround: 1'b1};
			2'b00:   m = '{positiveIsB: 1'b0, negativeIsB: 1'b1, negativeIsGround: 1'b0};
			default: m = '{positiveIsB: 1'b1, negativeIsB: 1'b0, negativeIsGround: 1'b0};
		endcase
		return m;
	endfunction

	sadc_pkg::sadc_state_e state;
	sadc_pkg::sadc_state_e next_state;
	logic [11:0] convCount;
	logic [11:0] next_convCount;
	logic [15:0] shiftReg;
	logic [15:0] next_shiftReg;
	logic [4:0]  bitCount;
	logic [4:0]  next_bitCount;
	logic [4:0]  sampleCount;
	logic [4:0]  next_sampleCount;
	logic [1:0]  cfgShift;
	logic [1:0]  next_cfgShift;
	logic [1:0]  cfgCount;
	logic [1:0]  next_cfgCount;
	logic [1:0]  muxWord;
	logic [1:0]  next_muxWord;
	logic        dataOut;
	logic        next_dataOut;
	logic        done;
	logic        next_done;

	localparam logic [11:0] SAMPLE_TRIGGER_LAST = 12'(sadc_pkg::QUANTIZE_CYCLES - 1);
	localparam logic [4:0]  SAMPLE_LEN = TWO_CHANNEL ? 5'(sadc_pkg::SAMPLE_CLOCKS_TWO)
		: 5'(sadc_pkg::SAMPLE_CLOCKS_ONE);

	// Conversion, sleep and transfer sequencing
	always_comb
	begin
		next_state       = state;
		next_convCount   = convCount;
		next_shiftReg    = shiftReg;
		next_bitCount    = bitCount;
		next_sampleCount = sampleCount;
		next_cfgShift    = cfgShift;
		next_cfgCount    = cfgCount;
		next_muxWord     = muxWord;
		next_dataOut     = dataOut;
		next_done        = done;
		case (state)
			sadc_pkg::SADC_SAMPLE:
			begin
				if (trigRise)
				begin
					next_state     = sadc_pkg::SADC_CONVERT;
					next_convCount = '0;
					next_done      = 1'b0;
					next_cfgCount  = '0; // New cycle re-arms config capture
					// Config taken this transfer steers the conversion now requested
					if (cfgCount == 2'(sadc_pkg::CONFIG_BITS))
						next_muxWord = cfgShift;
				end
				else
				begin
					if (sckRise)
					begin
						if (sampleCount < SAMPLE_LEN)
							next_sampleCount = sampleCount + 5'h1;
						// Full duplex capture alongside readout
						if (TWO_CHANNEL && cfgCount < 2'(sadc_pkg::CONFIG_BITS))
						begin
							next_cfgShift = {cfgShift[0], sdiSync[1]};
							next_cfgCount = cfgCount + 2'h1;
						end
					end
					if (sckFall)
					begin
						// MSB first, then zero fill forever
						next_dataOut  = shiftReg[15];
						next_shiftReg = {shiftReg[14:0], 1'b0};
						if (bitCount < 5'(sadc_pkg::RESULT_BITS))
							next_bitCount = bitCount + 5'h1;
					end
				end
			end
			sadc_pkg::SADC_CONVERT:
			begin
				if (convCount == SAMPLE_TRIGGER_LAST)
				begin
					next_done        = 1'b1;
					// Sampling interval restarts even when the trigger is already low
					next_sampleCount = '0;
					// Straight binary code latched as produced by the core
					next_dataOut  = convertedCode[15];
					next_shiftReg = {convertedCode[14:0], 1'b0};
					next_bitCount = 5'h1;
					next_state    = trigHigh ? sadc_pkg::SADC_SLEEP : sadc_pkg::SADC_SAMPLE;
				end
				else
					next_convCount = convCount + 12'h1;
			end
			sadc_pkg::SADC_SLEEP:
			begin
				if (trigFall)
				begin
					next_state       = sadc_pkg::SADC_SAMPLE;
					next_sampleCount = '0;
				end
			end
			default: next_state = sadc_pkg::SADC_SAMPLE;
		endcase
	end

	// Register the sequencer state, counters, shift and config registers, mux word and outputs
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state       <= sadc_pkg::SADC_SLEEP;
			convCount   <= '0;
			shiftReg    <= '0;
			bitCount    <= '0;
			sampleCount <= '0;
			cfgShift    <= '0;
			cfgCount    <= '0;
			muxWord     <= sadc_pkg::MUX_RESET;
			dataOut     <= 1'b0;
			done        <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			convCount   <= next_convCount;
			shiftReg    <= next_shiftReg;
			bitCount    <= next_bitCount;
			sampleCount <= next_sampleCount;
			cfgShift    <= next_cfgShift;
			cfgCount    <= next_cfgCount;
			muxWord     <= next_muxWord;
			dataOut     <= next_dataOut;
			done        <= next_done;
		end
	end

	// Output enable needs synchronised trigger low and a state other than convert, so a conversion never drives the pin
	assign serialResultOut = dataOut;
	assign serialResultOe  = !trigHigh && state != sadc_pkg::SADC_CONVERT;
	assign sampleMode      = state == sadc_pkg::SADC_SAMPLE && !trigHigh
		&& sampleCount < SAMPLE_LEN;
	assign sleepMode       = state == sadc_pkg::SADC_SLEEP;
	assign conversionDone  = done;
	assign muxSelect       = decodeMux(muxWord);

	// Cycles spent in the current conversion, kept apart from the sequencer
	// so that the check does not lean on the counter that it judges
	logic [11:0] convAge;
	logic [11:0] next_convAge;
	always_comb
	begin
		next_convAge = (state == sadc_pkg::SADC_CONVERT) ? convAge + 12'h1 : 12'h0;
	end
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			convAge <= 12'h0;
		else
			convAge <= next_convAge;
	end

	property p_sample_trigger_time;
		@(posedge clock) disable iff (!reset_n)
		(state != sadc_pkg::SADC_CONVERT && convAge != 12'h0)
			|-> convAge == 12'(sadc_pkg::QUANTIZE_CYCLES);
	endproperty
	a_sample_trigger_time: assert property (p_sample_trigger_time) else $error("conversion time wrong");

	property p_sample_trigger_bound;
		@(posedge clock) disable iff (!reset_n)
		(state == sadc_pkg::SADC_CONVERT) |-> convAge < 12'(sadc_pkg::QUANTIZE_CYCLES);
	endproperty
	a_sample_trigger_bound: assert property (p_sample_trigger_bound) else $error("conversion overran");

	property p_start;
		@(posedge clock) disable iff (!reset_n)
		(trigRise && state == sadc_pkg::SADC_SAMPLE) |=> state == sadc_pkg::SADC_CONVERT;
	endproperty
	a_start: assert property (p_start) else $error("conversion did not start");

	property p_sleep;
		@(posedge clock) disable iff (!reset_n)
		(state == sadc_pkg::SADC_CONVERT && convCount == SAMPLE_TRIGGER_LAST && trigHigh)
			|=> sleepMode;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered");

	property p_oe_off;
		@(posedge clock) disable iff (!reset_n)
		trigHigh |-> !serialResultOe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output on while trigger high");

	property p_shift;
		@(posedge clock) disable iff (!reset_n)
		(sckFall && state == sadc_pkg::SADC_SAMPLE && !trigRise)
			|=> serialResultOut == $past(shiftReg[15]);
	endproperty
	a_shift: assert property (p_shift) else $error("bit not shifted on falling edge");

	property p_zero;
		@(posedge clock) disable iff (!reset_n)
		(state == sadc_pkg::SADC_SAMPLE && bitCount == 5'(sadc_pkg::RESULT_BITS)
			&& sckFall && !trigRise) |=> !serialResultOut;
	endproperty
	a_zero: assert property (p_zero) else $error("zero fill missing");

	property p_cfg_limit;
		@(posedge clock) disable iff (!reset_n)
		(cfgCount == 2'h2 && !trigRise) |=> cfgCount == 2'h2 && $stable(cfgShift);
	endproperty
	a_cfg_limit: assert property (p_cfg_limit) else $error("extra config bit taken");

	property p_next_mux;
		@(posedge clock) disable iff (!reset_n)
		(!trigRise) |=> $stable(muxWord);
	endproperty
	a_next_mux: assert property (p_next_mux) else $error("mux changed mid transfer");

	// A complete word taken in the last transfer steers the conversion just started
	property p_mux_load;
		@(posedge clock) disable iff (!reset_n)
		(trigRise && state == sadc_pkg::SADC_SAMPLE && cfgCount == 2'(sadc_pkg::CONFIG_BITS))
			|=> muxWord == $past(cfgShift);
	endproperty
	a_mux_load: assert property (p_mux_load) else $error("config word not applied");

endmodule // sadc_serial_interface
`default_nettype wire

// file: tb/sadc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model (
	input  wire logic serialResultOut,
	output logic      sampleTrigger,
	output logic      shiftClock,
	output logic      serialConfigIn
);
	logic [31:0] captured;
	logic [1:0]  configWord;
	int          bitIdx;
	// Link clock idles low and stands still between frames
	initial
	begin
		sampleTrigger = 1'b0;
		shiftClock = 1'b0;
		serialConfigIn = 1'b0;
		captured = 32'h0;
		configWord = 2'h2;
		bitIdx = 0;
	end
	// High time is held by the caller until the conversion reports done
	task automatic startConversion();
		sampleTrigger = 1'b1;
	endtask
	// Pair select goes first; the gap keeps the first rise clear of the fall
	task automatic beginFrame(input logic [1:0] cfg);
		configWord = cfg;
		bitIdx = 0;
		captured = 32'h0;
		serialConfigIn = cfg[1];
		sampleTrigger = 1'b0;
		#100;
	endtask
	// Capture on rise, change on fall; surplus config bits toggle as junk
	task automatic shift(input int n);
		repeat (n)
		begin
			#62.5 shiftClock = 1'b1;
			captured = {captured[30:0], serialResultOut};
			#62.5 shiftClock = 1'b0;
			bitIdx++;
			serialConfigIn = (bitIdx == 1) ? configWord[0] : ~serialConfigIn;
		end
	endtask
endmodule // sadc_host_model
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                clock;
	logic                reset_n;
	logic [15:0]         convertedCode;
	logic                sampleTrigger;
	logic                shiftClock;
	logic                serialConfigIn;
	logic                serialResultOut;
	logic                serialResultOe;
	logic                sampleMode;
	logic                sleepMode;
	logic                conversionDone;
	sadc_pkg::sadc_mux_s muxSelect;
	logic                serialResultOutOne;
	logic                sampleModeOne;
	sadc_pkg::sadc_mux_s muxSelectOne;
	int                  nFail;
	int                  checksDone;
	logic [15:0]         codes [4] = '{16'h0000, 16'hffff, 16'ha5c3, 16'h8001};
	logic [1:0]          cfgs [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	sadc_serial_interface u_dut (.clock(clock), .reset_n(reset_n),
		.sampleTrigger(sampleTrigger), .shiftClock(shiftClock),
		.serialConfigIn(serialConfigIn), .convertedCode(convertedCode),
		.serialResultOut(serialResultOut), .serialResultOe(serialResultOe),
		.sampleMode(sampleMode), .sleepMode(sleepMode),
		.conversionDone(conversionDone), .muxSelect(muxSelect));
	// One-channel build on the same pins: config ignored, longer sampling
	sadc_serial_interface #(.TWO_CHANNEL(1'b0)) u_dut_one (.clock(clock),
		.reset_n(reset_n), .sampleTrigger(sampleTrigger), .shiftClock(shiftClock),
		.serialConfigIn(serialConfigIn), .convertedCode(convertedCode),
		.serialResultOut(serialResultOutOne), .serialResultOe(),
		.sampleMode(sampleModeOne), .sleepMode(), .conversionDone(),
		.muxSelect(muxSelectOne));
	sadc_host_model u_host (.serialResultOut(serialResultOut),
		.sampleTrigger(sampleTrigger), .shiftClock(shiftClock),
		.serialConfigIn(serialConfigIn));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			nFail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic testDone();
		$display("checks %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic waitCycles(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Expected selection as {positiveIsB, negativeIsB, negativeIsGround}
	function automatic logic [31:0] expMux(input logic [1:0] cfg);
		case (cfg)
			2'h2: return 32'h1;
			2'h3: return 32'h5;
			2'h0: return 32'h2;
			default: return 32'h4;
		endcase
	endfunction
	task automatic testReset();
		check(32'({serialResultOe, sleepMode, conversionDone}), 32'h2);
		check(32'(muxSelect), expMux(2'h2));
		$display("reset test done");
	endtask
	// One full cycle: convert, sleep, then a 20-clock full-duplex frame
	task automatic testFrame(input logic [15:0] code, input logic [1:0] cfg,
		input logic [1:0] prevCfg);
		int n;
		convertedCode = code;
		u_host.startConversion();
		waitCycles(5);
		check(32'({serialResultOe, conversionDone}), 32'h0);
		check(32'(muxSelect), expMux(prevCfg));
		n = 5;
		// Look just after each edge, once the registered flag has settled
		while (conversionDone !== 1'b1 && n < 400)
		begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 400)
		begin
			nFail++;
			testDone();
		end
		// Two clocks of pin synchronisation and one to enter convert come before the quantize time
		check(32'(n), 32'(sadc_pkg::QUANTIZE_CYCLES + 3));
		waitCycles(20);
		check(32'({sleepMode, serialResultOe}), 32'h2);
		check(32'({serialResultOut, serialResultOutOne}), {30'h0, code[15], code[15]});
		u_host.beginFrame(cfg);
		check(32'({serialResultOe, sampleMode, sleepMode}), 32'h6);
		u_host.shift(13);
		check(32'(sampleMode), 32'h1);
		u_host.shift(2);
		check(32'(sampleMode), 32'h0);
		check(32'(sampleModeOne), 32'h1);
		u_host.shift(5);
		check(32'(sampleModeOne), 32'h0);
		check(u_host.captured & 32'hfffff, {12'h0, code, 4'h0});
		check(32'(muxSelect), expMux(prevCfg));
		check(32'(muxSelectOne), expMux(2'h2));
		waitCycles(2);
		$display("frame test done for code %h", code);
	endtask
	initial
	begin
		reset_n = 1'b0;
		convertedCode = 16'h0;
		nFail = 0;
		checksDone = 0;
		waitCycles(1);
		testReset();
		waitCycles(3);
		reset_n = 1'b1;
		waitCycles(2);
		// Previous word applies only to the following conversion
		for (int i = 0; i < 4; i++)
			testFrame(codes[i], cfgs[i], (i == 0) ? 2'h2 : cfgs[i - 1]);
		u_host.startConversion();
		waitCycles(10);
		check(32'(muxSelect), expMux(cfgs[3]));
		testDone();
	end
endmodule // testbench
`default_nettype wire
